// file: pds_pkg.sv
package pds_pkg;

  // ---------------------------------------------------------------------
  // widths of the programmable counters, bus and select, and the latch count
  // ---------------------------------------------------------------------
  localparam int unsigned MAIN_W  = 10;
  localparam int unsigned SWAL_W  = 7;
  localparam int unsigned REF_W   = 11;
  localparam int unsigned NIB_W   = 4;
  localparam int unsigned SEL_W   = 3;
  localparam int unsigned NUM_LAT = 8;

  // ---------------------------------------------------------------------
  // latch select values, one per programming word
  // ---------------------------------------------------------------------
  localparam logic [2:0] SEL_MAIN_LOW  = 3'h0;
  localparam logic [2:0] SEL_MAIN_MID  = 3'h1;
  localparam logic [2:0] SEL_MAIN_HIGH = 3'h2;
  localparam logic [2:0] SEL_SWAL_LOW  = 3'h3;
  localparam logic [2:0] SEL_SWAL_HIGH = 3'h4;
  localparam logic [2:0] SEL_REF_LOW   = 3'h5;
  localparam logic [2:0] SEL_REF_MID   = 3'h6;
  localparam logic [2:0] SEL_REF_HIGH  = 3'h7;

  // ---------------------------------------------------------------------
  // field positions inside the nibbles
  // ---------------------------------------------------------------------
  localparam int unsigned MAIN_LOW_LSB = 2;  // main bits 1:0 on lines 3:2
  localparam int unsigned TOP3_MSB     = 2;  // partial words use lines 2:0

  // ---------------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------------
  localparam logic [3:0] NIB_RST        = 4'h0;
  localparam int unsigned CLK_MHZ       = 40;
  localparam int unsigned FINE_WIN_NS   = 500;
  localparam int unsigned FINE_WIN_CYC  = (FINE_WIN_NS * CLK_MHZ) / 1000;
  localparam int unsigned ERR_W         = 8;

  // committed divider values travel together
  typedef struct packed {
    logic [MAIN_W-1:0] main_val;
    logic [SWAL_W-1:0] swal_val;
    logic [REF_W-1:0]  ref_val;
  } pds_prog_t;

  localparam pds_prog_t PROG_RST = '0;

endpackage

// file: pds_synth.sv
`timescale 1ns/1ps
`default_nettype none
module pds_synth
#(
  parameter int unsigned FINE_WIN = pds_pkg::FINE_WIN_CYC
)
(
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       clk_en_i,
  input  wire logic [3:0] nibble_bus_i,
  input  wire logic [2:0] latch_select_i,
  input  wire logic       latch_strobe_i,
  input  wire logic       osc_ref_i,
  input  wire logic       prescaler_input_i,
  output logic            modulus_control_out_o,
  output logic            coarse_phase_out_o,
  output logic            coarse_phase_oe_o,
  output logic            lock_flag_out_o,
  output logic            lock_flag_oe_o,
  output logic            divided_input_tick_o,
  output logic            divided_reference_tick_o
);

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  // count down, reloading only from the zero state
  function automatic logic [pds_pkg::REF_W-1:0] count_down
  (
    input logic [pds_pkg::REF_W-1:0] cur,
    input logic [pds_pkg::REF_W-1:0] load
  );
    count_down = (cur == '0) ? load : cur - 1'b1;
  endfunction

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  logic [9:0] pin_m_q;
  logic [9:0] pin_s_q;
  logic [3:0] bus_s_q;
  logic [2:0] sel_s_q;
  logic       stb_s_q;
  logic       osc_s_q;
  logic       osc_d_q;
  logic       fin_s_q;
  logic       fin_d_q;
  logic       osc_rise;
  logic       fin_rise;

  // every pin crosses two flops; edge detectors read only the second
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pin_m_q <= 10'h000;
      pin_s_q <= 10'h000;
      osc_d_q <= 1'b0;
      fin_d_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      pin_m_q <= {nibble_bus_i, latch_select_i, latch_strobe_i, osc_ref_i,
                  prescaler_input_i};
      pin_s_q <= pin_m_q;
      osc_d_q <= osc_s_q;
      fin_d_q <= fin_s_q;
    end
  end

  // all pins share one delay, so select, data and strobe stay aligned
  assign {bus_s_q, sel_s_q, stb_s_q, osc_s_q, fin_s_q} = pin_s_q;

  // counters step on rising input edges only
  assign osc_rise = osc_s_q & ~osc_d_q;
  assign fin_rise = fin_s_q & ~fin_d_q;

  // ---------------------------------------------------------------------
  // programming latches
  // ---------------------------------------------------------------------
  logic [3:0]        latch_q [pds_pkg::NUM_LAT];
  pds_pkg::pds_prog_t prog_q;
  logic              wr_word1;

  assign wr_word1 = stb_s_q & (sel_s_q == pds_pkg::SEL_MAIN_LOW);

  // level-sensitive strobe: latch follows the bus while high; no reset
  // exists on the real part so these only read zero until written
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < pds_pkg::NUM_LAT; i++)
      begin
        latch_q[i] <= pds_pkg::NIB_RST;
      end
    end
    else if (clk_en_i && stb_s_q)
    begin
      latch_q[sel_s_q] <= bus_s_q;
    end
  end

  // word 1 commits every latch at once, its own bits taken from the bus
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      prog_q <= pds_pkg::PROG_RST;
    end
    else if (clk_en_i && wr_word1)
    begin
      prog_q.main_val <= {latch_q[pds_pkg::SEL_MAIN_HIGH],
                          latch_q[pds_pkg::SEL_MAIN_MID],
                          bus_s_q[3:pds_pkg::MAIN_LOW_LSB]};
      prog_q.swal_val <= {latch_q[pds_pkg::SEL_SWAL_HIGH][2:0],
                          latch_q[pds_pkg::SEL_SWAL_LOW]};
      prog_q.ref_val  <= {latch_q[pds_pkg::SEL_REF_HIGH][2:0],
                          latch_q[pds_pkg::SEL_REF_MID],
                          latch_q[pds_pkg::SEL_REF_LOW]};
    end
  end

  // ---------------------------------------------------------------------
  // reference divider
  // ---------------------------------------------------------------------
  logic [pds_pkg::REF_W-1:0] ref_cnt_q;
  logic                      ref_half_q;

  // half period of r oscillator edges gives a division of 2r
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ref_cnt_q  <= '0;
      ref_half_q <= 1'b0;
    end
    else if (clk_en_i && osc_rise)
    begin
      ref_cnt_q <= count_down(ref_cnt_q, prog_q.ref_val - 1'b1);
      if (ref_cnt_q == '0)
      begin
        ref_half_q <= ~ref_half_q;
      end
    end
  end

  // one-cycle reference tick on the rising half
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      divided_reference_tick_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      divided_reference_tick_o <= osc_rise & (ref_cnt_q == '0)
                                  & ~ref_half_q;
    end
  end

  // ---------------------------------------------------------------------
  // main and swallow counters
  // ---------------------------------------------------------------------
  logic [pds_pkg::MAIN_W-1:0] main_cnt_q;
  logic [pds_pkg::SWAL_W-1:0] swal_cnt_q;
  logic [pds_pkg::SWAL_W-1:0] swal_nxt;
  logic [pds_pkg::REF_W-1:0]  main_nxt_w;

  assign main_nxt_w = count_down({1'b0, main_cnt_q},
                                 {1'b0, prog_q.main_val - 1'b1});

  // swallow reloads only together with main, otherwise stops at zero
  assign swal_nxt = (main_cnt_q == '0) ? prog_q.swal_val
                  : (swal_cnt_q != '0) ? swal_cnt_q - 1'b1
                  : swal_cnt_q;

  // main counts m prescaler edges per cycle; swallow rides inside it
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      main_cnt_q            <= '0;
      swal_cnt_q            <= '0;
      modulus_control_out_o <= 1'b1;
    end
    else if (clk_en_i && fin_rise)
    begin
      main_cnt_q            <= main_nxt_w[pds_pkg::MAIN_W-1:0];
      swal_cnt_q            <= swal_nxt;
      modulus_control_out_o <= (swal_nxt == '0);
    end
  end

  // end of the main cycle is the divided input compared by the detector
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      divided_input_tick_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      divided_input_tick_o <= fin_rise & (main_cnt_q == '0);
    end
  end

  // ---------------------------------------------------------------------
  // phase/frequency detector and lock
  // ---------------------------------------------------------------------
  logic                    up_q;
  logic                    dn_q;
  logic [pds_pkg::ERR_W-1:0] err_q;
  logic                    in_win;
  logic                    close_now;
  logic                    lock_nxt;

  assign in_win    = (err_q < pds_pkg::ERR_W'(FINE_WIN));
  assign close_now = (up_q | divided_input_tick_o)
                     & (dn_q | divided_reference_tick_o);
  // an error pulse wider than the window drops lock; a close inside it
  // sets lock, so the coarse enable never overlaps the lock pull-down
  assign lock_nxt  = ((up_q | dn_q) && !in_win) ? 1'b0
                     : close_now ? in_win : lock_flag_oe_o;

  // classic two-flop detector; both set clears both, error width counted
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      up_q  <= 1'b0;
      dn_q  <= 1'b0;
      err_q <= '0;
    end
    else if (clk_en_i)
    begin
      if (close_now)
      begin
        up_q  <= 1'b0;
        dn_q  <= 1'b0;
        err_q <= '0;
      end
      else
      begin
        up_q <= up_q | divided_input_tick_o;
        dn_q <= dn_q | divided_reference_tick_o;
        if ((up_q | dn_q) && (err_q != '1))
        begin
          err_q <= err_q + 1'b1; // saturates, avoids false window on wrap
        end
      end
    end
  end

  // coarse drives during an error pulse while unlocked or once the error leaves the window
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      coarse_phase_out_o <= 1'b0;
      coarse_phase_oe_o  <= 1'b0;
      lock_flag_out_o    <= 1'b0;
      lock_flag_oe_o     <= 1'b0;
    end
    else if (clk_en_i)
    begin
      coarse_phase_out_o <= up_q;
      coarse_phase_oe_o  <= (up_q | dn_q) & ~lock_nxt;
      lock_flag_out_o    <= 1'b0; // open drain only ever pulls low
      lock_flag_oe_o     <= lock_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_capture;
    clk_en_i && stb_s_q && sel_s_q == pds_pkg::SEL_SWAL_LOW
      |=> latch_q[pds_pkg::SEL_SWAL_LOW] == $past(bus_s_q);
  endproperty
  a_capture: assert property (p_capture) else $error("latch miss");

  property p_hold;
    !stb_s_q |=> latch_q[pds_pkg::SEL_REF_HIGH]
                 == $past(latch_q[pds_pkg::SEL_REF_HIGH]);
  endproperty
  a_hold: assert property (p_hold) else $error("latch moved");

  property p_commit;
    clk_en_i && wr_word1 |=> prog_q.main_val[1:0] == $past(bus_s_q[3:2])
      && prog_q.ref_val[3:0] == $past(latch_q[pds_pkg::SEL_REF_LOW]);
  endproperty
  a_commit: assert property (p_commit) else $error("bad commit");

  property p_main_step;
    clk_en_i && fin_rise && main_cnt_q != '0
      |=> main_cnt_q == $past(main_cnt_q) - 1'b1;
  endproperty
  a_main_step: assert property (p_main_step) else $error("main step");

  property p_main_load;
    clk_en_i && fin_rise && main_cnt_q == '0
      |=> main_cnt_q == $past(prog_q.main_val) - 1'b1
          && swal_cnt_q == $past(prog_q.swal_val) && divided_input_tick_o;
  endproperty
  a_main_load: assert property (p_main_load) else $error("main load");

  property p_modctl;
    clk_en_i && fin_rise && modulus_control_out_o && main_cnt_q != '0
      |=> modulus_control_out_o;
  endproperty
  a_modctl: assert property (p_modctl) else $error("modulus ctl");

  property p_mod_low;
    clk_en_i && fin_rise && main_cnt_q == '0 && prog_q.swal_val != '0
      |=> !modulus_control_out_o;
  endproperty
  a_mod_low: assert property (p_mod_low) else $error("modulus low");

  property p_ref_load;
    clk_en_i && osc_rise && ref_cnt_q == '0
      |=> ref_cnt_q == $past(prog_q.ref_val) - 1'b1
          && ref_half_q != $past(ref_half_q);
  endproperty
  a_ref_load: assert property (p_ref_load) else $error("ref load");

  property p_tick_pulse;
    clk_en_i && divided_reference_tick_o |=> !divided_reference_tick_o;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("ref tick");

  property p_lock_low;
    lock_flag_oe_o |-> !lock_flag_out_o && !coarse_phase_oe_o
                       || (up_q | dn_q);
  endproperty
  a_lock_low: assert property (p_lock_low) else $error("lock level");

  property p_coarse_dir;
    clk_en_i && coarse_phase_oe_o && coarse_phase_out_o
      |-> $past(up_q) && !$past(dn_q);
  endproperty
  a_coarse_dir: assert property (p_coarse_dir) else $error("coarse dir");

endmodule
`default_nettype wire

// file: pds_host.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// host model: writes programming words one strobe at a time
// ---------------------------------------------------------------
module pds_host
(
  input  wire logic       clk_i,
  output logic [3:0]      nibble_bus_o,
  output logic [2:0]      latch_select_o,
  output logic            latch_strobe_o
);
  logic busy = 1'b0;

  initial
  begin
    nibble_bus_o   = 4'h5;
    latch_select_o = 3'h0;
    latch_strobe_o = 1'b0;
  end

  // a released bus keeps changing, so a stale value never looks valid
  always @(posedge clk_i)
    if (!busy)
      nibble_bus_o <= ~nibble_bus_o;

  // select and data settle before the strobe and outlast it
  task automatic put(input logic [2:0] s, input logic [3:0] n);
    @(negedge clk_i);
    busy           = 1'b1;
    latch_select_o = s;
    nibble_bus_o   = n;
    repeat (4) @(negedge clk_i);
    latch_strobe_o = 1'b1;
    repeat (3) @(negedge clk_i);
    latch_strobe_o = 1'b0;
    repeat (4) @(negedge clk_i);
    busy = 1'b0;
  endtask

  // unused bits carry ones on purpose; word 1 goes last to commit
  task automatic prog(input logic [9:0] m, input logic [6:0] a,
                      input logic [10:0] r);
    put(3'h1, m[5:2]);
    put(3'h2, m[9:6]);
    put(3'h3, a[3:0]);
    put(3'h4, {1'b1, a[6:4]});
    put(3'h5, r[3:0]);
    put(3'h6, r[7:4]);
    put(3'h7, {1'b1, r[10:8]});
    put(3'h0, {m[1:0], 2'b11});
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        clk_en_i = 1'b1;
  logic [3:0]  nib;
  logic [2:0]  sel;
  logic        stb;
  logic        osc_ref_i = 1'b0;
  logic        prescaler_input_i = 1'b0;
  logic        mod_o, cp_o, cp_oe, lk_o, lk_oe, in_t, ref_t;
  logic [5:0]  snap;
  int          fails = 0;
  int          check_count = 0;
  int          fin_e, osc_e, fin_m, osc_m, fin_per, osc_per;
  int          low_acc, low_per, fin_t, osc_t, fph, oph, m, a, r;
  logic [31:0] rs = 32'hd09c_54fd;
  int          tbl[$] = '{3, 0, 3, 3, 3, 3, 1023, 127, 3};

  always #12.5 clk_i = ~clk_i;

  pds_host host_u
  (
    .clk_i          (clk_i),
    .nibble_bus_o   (nib),
    .latch_select_o (sel),
    .latch_strobe_o (stb)
  );

  pds_synth #(.FINE_WIN(4)) dut_u
  (
    .clk_i                    (clk_i),
    .sys_rst_i                (sys_rst_i),
    .clk_en_i                 (clk_en_i),
    .nibble_bus_i             (nib),
    .latch_select_i           (sel),
    .latch_strobe_i           (stb),
    .osc_ref_i                (osc_ref_i),
    .prescaler_input_i        (prescaler_input_i),
    .modulus_control_out_o    (mod_o),
    .coarse_phase_out_o       (cp_o),
    .coarse_phase_oe_o        (cp_oe),
    .lock_flag_out_o          (lk_o),
    .lock_flag_oe_o           (lk_oe),
    .divided_input_tick_o     (in_t),
    .divided_reference_tick_o (ref_t)
  );

  // ---------------------------------------------------------------
  // stimulus clocks and reference counts
  // ---------------------------------------------------------------
  // prescaler period 8 clocks, oscillator 6: both slower than clk/3
  always @(negedge clk_i)
  begin
    fph = (fph + 1) % 8;
    oph = (oph + 1) % 6;
    prescaler_input_i <= (fph < 4);
    osc_ref_i <= (oph < 3);
    if (fph == 0)
      fin_e++;
    if (oph == 0)
      osc_e++;
    if (fph == 0 && mod_o === 1'b0)
      low_acc++;
  end

  // model: edges per output tick, edges seen with modulus low
  always @(posedge clk_i)
  begin
    if (in_t === 1'b1)
    begin
      fin_per = fin_e - fin_m;
      fin_m   = fin_e;
      low_per = low_acc;
      low_acc = 0;
      fin_t++;
    end
    if (ref_t === 1'b1)
    begin
      osc_per = osc_e - osc_m;
      osc_m   = osc_e;
      osc_t++;
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic finish_test();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // new values only land at a counter's zero, so skip early periods
  task automatic settle(input int n);
    int k;
    k = 0;
    fin_t = 0;
    osc_t = 0;
    while ((fin_t < n || osc_t < n) && k < 60000)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 60000)
    begin
      fails++;
      finish_test();
    end
  endtask

  task automatic run(input int mm, input int aa, input int rr);
    host_u.prog(mm[9:0], aa[6:0], rr[10:0]);
    settle(4);
    chk(fin_per, mm);
    chk(low_per, aa);
    chk(osc_per, 2 * rr);
    chk(lk_o, 1'b0);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (5) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    for (int i = 0; i < tbl.size(); i += 3)
      run(tbl[i], tbl[i + 1], tbl[i + 2]);
    // divided input far slower than reference: unlocked, coarse drives down
    repeat (80) @(negedge clk_i);
    chk(lk_oe, 1'b0);
    chk(cp_oe, 1'b1);
    chk(cp_o, 1'b0);
    repeat (3)
    begin
      rs = xs(rs);
      m  = 3 + rs[7:0];
      a  = rs[14:8] % (m + 1);
      r  = 3 + rs[22:16];
      run(m, a, r);
    end
    // clock enable low freezes every output
    @(negedge clk_i);
    clk_en_i = 1'b0;
    snap     = {mod_o, cp_o, cp_oe, lk_oe, in_t, ref_t};
    repeat (40) @(negedge clk_i);
    chk({mod_o, cp_o, cp_oe, lk_oe, in_t, ref_t}, snap);
    clk_en_i = 1'b1;
    // a latch write without word 1 must leave the counters alone; the
    // raised high word keeps main at least the swallow value
    host_u.put(3'h2, m[9:6] + 4'h1);
    settle(4);
    chk(fin_per, m);
    host_u.put(3'h0, {m[1:0], 2'b11});
    settle(4);
    m = m + 64;
    chk(fin_per, m);
    finish_test();
  end
endmodule
`default_nettype wire
